// file: cfu_map.svh
// Purpose: Offsets, field positions and reset values of the condition flag unit
// Assumes: Included by bare name from the modules; the package does not include it
// Notes:   Definitions only
`ifndef CFU_MAP_SVH
`define CFU_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, word aligned)
// ----------------------------------------------------------------
`define CFU_FLAGS_OFS     8'h00
`define CFU_EVENT_OFS     8'h04

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define CFU_BIT_SXOR      7
`define CFU_BIT_CHAIN     6
`define CFU_BIT_WDEXP     5
`define CFU_BIT_PDOWN     4
`define CFU_BIT_OVF       3
`define CFU_BIT_ZERO      2
`define CFU_BIT_NIB       1
`define CFU_BIT_CARRY     0

// ----------------------------------------------------------------
// Reset value and software write mask
// ----------------------------------------------------------------
`define CFU_FLAGS_RST     8'h00
`define CFU_SW_WR_MASK    8'h0F

`endif

// file: cfu_pkg.sv
// Purpose: Types shared by the condition flag unit
// Assumes: Nothing
// Notes:   Operation classes of the ALU as seen by the flag logic
`default_nettype none
package cfu_pkg;

    typedef enum logic [3:0] {
        CFU_OP_NONE,
        CFU_OP_ADD,
        CFU_OP_SUB,
        CFU_OP_SUB_BORROW,
        CFU_OP_LOGIC,
        CFU_OP_ROT_LEFT_CARRY,
        CFU_OP_ROT_RIGHT_CARRY
    } cfu_op_t;

    // One ALU operation with its operands and result
    typedef struct packed {
        logic       valid;
        cfu_op_t    op;
        logic [7:0] opnd_a;
        logic [7:0] opnd_b;
        logic       carry_in;
        logic [7:0] result;
    } cfu_alu_req_t;

    // Core management events, one-cycle pulses
    typedef struct packed {
        logic watchdog_kick_instruction;
        logic sleep_entry_instruction;
        logic watchdog_timeout;
    } cfu_sys_evt_t;

endpackage : cfu_pkg

`default_nettype wire

// file: cfu_alu_eval.sv
// Purpose: Combinational evaluation of arithmetic flag values for one operation
// Assumes: Operands are the ALU inputs, result is the ALU output
// Notes:   Subtraction is a + ~b + carry_in (carry_in is 1 for plain subtract)
`timescale 1ns/1ps
`default_nettype none
`include "cfu_map.svh"

module cfu_alu_eval (
    input  wire cfu_pkg::cfu_alu_req_t req_in,
    input  wire logic                  carry_flag_in,
    output logic                       carry_out,
    output logic                       nib_out,
    output logic                       zero_out,
    output logic                       ovf_out,
    output logic                       sxor_out,
    output logic                       carry_upd_out,
    output logic                       arith_upd_out
);
    wire        is_add  = (req_in.op == cfu_pkg::CFU_OP_ADD);
    wire        is_sub  = (req_in.op == cfu_pkg::CFU_OP_SUB) ||
                          (req_in.op == cfu_pkg::CFU_OP_SUB_BORROW);
    wire        is_rl   = (req_in.op == cfu_pkg::CFU_OP_ROT_LEFT_CARRY);
    wire        is_rr   = (req_in.op == cfu_pkg::CFU_OP_ROT_RIGHT_CARRY);
    wire [7:0]  opnd_b  = is_sub ? ~req_in.opnd_b : req_in.opnd_b;
    wire        cin     = (is_add || is_sub) ? req_in.carry_in : 1'h0;
    wire [4:0]  low_sum = {1'h0, req_in.opnd_a[3:0]} + {1'h0, opnd_b[3:0]} + {4'h0, cin};
    wire [7:0]  low7    = {1'h0, req_in.opnd_a[6:0]} + {1'h0, opnd_b[6:0]} + {7'h00, cin};
    wire [8:0]  full    = {1'h0, req_in.opnd_a} + {1'h0, opnd_b} + {8'h00, cin};
    wire        arith   = is_add || is_sub;

    // Borrow-free subtract shows as carry out of a + ~b + 1
    assign carry_out     = is_rl ? req_in.opnd_a[7] :
                           is_rr ? req_in.opnd_a[0] : full[8];
    assign nib_out       = low_sum[4];
    assign zero_out      = (req_in.result == 8'h00);
    assign ovf_out       = low7[7] ^ full[8];
    assign sxor_out      = (arith ? ovf_out : 1'h0) ^ req_in.result[7];
    assign carry_upd_out = req_in.valid && (arith || is_rl || is_rr);
    assign arith_upd_out = req_in.valid && arith;
endmodule : cfu_alu_eval

`default_nettype wire

// file: cfu_flag_unit.sv
// Purpose: Condition flag unit with its flag register on classic Wishbone
// Assumes: One ALU operation per valid cycle; events are same-domain pulses
// Overview of operation
// - Eight-bit flag register, fixed bit layout
// - Writes never change watchdog or powerdown flags
// - Other writable flags behave as ordinary register bits
// - Flags follow latest operation, else hold
// - Watchdog flag: clear kick/sleep/reset, set timeout
// - Powerdown flag: clear kick/reset, set sleep
// - Sign xor is overflow xor result MSB
// - Subtract loads chained zero from zero
// - Borrow subtract ANDs chained zero with zero
// - Other instructions keep chained zero
// - Carry: add carry out, subtract no borrow
// - Rotate through carry exchanges carry bit
// - Nibble flag: low nibble carry, no borrow
// - Zero flag set on all-zero add, subtract or logic result
// - Overflow: carry into MSB differs from out
`timescale 1ns/1ps
`default_nettype none
`include "cfu_map.svh"

module cfu_flag_unit (
    input  wire logic                  ref_clk_in,
    input  wire logic                  sys_rst_in,
    // Classic Wishbone slave
    input  wire logic                  wb_cyc_in,
    input  wire logic                  wb_stb_in,
    input  wire logic                  wb_we_in,
    input  wire logic [7:0]            wb_adr_in,
    input  wire logic [3:0]            wb_sel_in,
    input  wire logic [31:0]           wb_dat_in,
    output logic      [31:0]           wb_dat_out,
    output logic                       wb_ack_out,
    output logic                       wb_err_out,
    // Core side
    input  wire cfu_pkg::cfu_alu_req_t alu_req_in,
    input  wire cfu_pkg::cfu_sys_evt_t sys_evt_in,
    output logic      [7:0]            flags_out
);
    // ----------------------------------------------------------------
    // Flag state
    // ----------------------------------------------------------------
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic       ack_q;
    logic       err_q;
    logic [31:0] rdata_q;

    // ----------------------------------------------------------------
    // Flag evaluation
    // ----------------------------------------------------------------
    logic ev_carry;
    logic ev_nib;
    logic ev_zero;
    logic ev_ovf;
    logic ev_sxor;
    logic ev_carry_upd;
    logic ev_arith_upd;

    cfu_alu_eval u_eval (
        .req_in        (alu_req_in),
        .carry_flag_in (flags[`CFU_BIT_CARRY]),
        .carry_out     (ev_carry),
        .nib_out       (ev_nib),
        .zero_out      (ev_zero),
        .ovf_out       (ev_ovf),
        .sxor_out      (ev_sxor),
        .carry_upd_out (ev_carry_upd),
        .arith_upd_out (ev_arith_upd)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire bus_req   = wb_cyc_in && wb_stb_in && !ack_q && !err_q;
    wire hit_flags = (wb_adr_in == `CFU_FLAGS_OFS);
    wire hit_event = (wb_adr_in == `CFU_EVENT_OFS);
    wire mapped    = hit_flags || hit_event;
    wire sw_wr     = bus_req && wb_we_in && hit_flags && wb_sel_in[0];
    // Event word is read-only status of the pending kick/sleep/timeout inputs
    wire [7:0] evt_view = {5'h00, sys_evt_in.watchdog_timeout,
                           sys_evt_in.sleep_entry_instruction,
                           sys_evt_in.watchdog_kick_instruction};

    wire is_sub_plain  = alu_req_in.valid && (alu_req_in.op == cfu_pkg::CFU_OP_SUB);
    wire is_sub_borrow = alu_req_in.valid && (alu_req_in.op == cfu_pkg::CFU_OP_SUB_BORROW);
    wire is_logic      = alu_req_in.valid && (alu_req_in.op == cfu_pkg::CFU_OP_LOGIC);

    // Software bits mask: only overflow, zero, nibble and carry are writable
    wire [7:0] sw_mask  = `CFU_SW_WR_MASK;
    wire [7:0] sw_value = (flags & ~sw_mask) | (wb_dat_in[7:0] & sw_mask);

    // ----------------------------------------------------------------
    // Next flag value
    // ----------------------------------------------------------------
    // A bus write lands first; an ALU result in the same cycle overrides
    // the bits it updates, since hardware events win over software.
    always_comb begin
        next_flags = sw_wr ? sw_value : flags;
        if (ev_carry_upd) begin
            next_flags[`CFU_BIT_CARRY] = ev_carry;
        end
        if (ev_arith_upd) begin
            next_flags[`CFU_BIT_NIB]  = ev_nib;
            next_flags[`CFU_BIT_OVF]  = ev_ovf;
            next_flags[`CFU_BIT_SXOR] = ev_sxor;
        end
        if (ev_arith_upd || is_logic) begin
            next_flags[`CFU_BIT_ZERO] = ev_zero;
        end
        // Logic operations keep overflow, so sign xor uses the flag as it stands
        if (is_logic) begin
            next_flags[`CFU_BIT_SXOR] = next_flags[`CFU_BIT_OVF] ^ alu_req_in.result[7];
        end
        if (is_sub_plain) begin
            next_flags[`CFU_BIT_CHAIN] = ev_zero;
        end else if (is_sub_borrow) begin
            next_flags[`CFU_BIT_CHAIN] = flags[`CFU_BIT_CHAIN] & ev_zero;
        end
        // Timeout wins over a clear in the same cycle
        if (sys_evt_in.watchdog_kick_instruction || sys_evt_in.sleep_entry_instruction) begin
            next_flags[`CFU_BIT_WDEXP] = 1'h0;
        end
        if (sys_evt_in.watchdog_timeout) begin
            next_flags[`CFU_BIT_WDEXP] = 1'h1;
        end
        if (sys_evt_in.watchdog_kick_instruction) begin
            next_flags[`CFU_BIT_PDOWN] = 1'h0;
        end
        if (sys_evt_in.sleep_entry_instruction) begin
            next_flags[`CFU_BIT_PDOWN] = 1'h1;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            flags <= `CFU_FLAGS_RST;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ack_q   <= 1'h0;
            err_q   <= 1'h0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q   <= bus_req && mapped;
            err_q   <= bus_req && !mapped;
            rdata_q <= (bus_req && hit_flags) ? {24'h000000, flags} :
                       (bus_req && hit_event) ? {24'h000000, evt_view} : 32'h00000000;
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_err_out = err_q;
    assign wb_dat_out = rdata_q;
    assign flags_out  = flags;
endmodule : cfu_flag_unit

`default_nettype wire

// file: cfu_flag_unit_assertions.sv
// Purpose: Port-level checks of the condition flag unit
// Assumes: Bound to every instance of cfu_flag_unit
// Notes:   One clock domain, so one default clocking and disable
`timescale 1ns/1ps
`default_nettype none
module cfu_flag_unit_assertions (
    input wire logic                  ref_clk_in,
    input wire logic                  sys_rst_in,
    input wire logic                  wb_cyc_in,
    input wire logic                  wb_stb_in,
    input wire logic                  wb_ack_out,
    input wire logic                  wb_err_out,
    input wire cfu_pkg::cfu_alu_req_t alu_req_in,
    input wire cfu_pkg::cfu_sys_evt_t sys_evt_in,
    input wire logic [7:0]            flags_out
);
    wire logic take  = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
    wire logic vld   = alu_req_in.valid;
    wire logic is_sub = vld && alu_req_in.op == cfu_pkg::CFU_OP_SUB;
    wire logic is_sbc = vld && alu_req_in.op == cfu_pkg::CFU_OP_SUB_BORROW;
    wire logic is_ari = is_sub || is_sbc || (vld && alu_req_in.op == cfu_pkg::CFU_OP_ADD);
    wire logic sets_z = is_ari || (vld && alu_req_in.op == cfu_pkg::CFU_OP_LOGIC);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_bus_answer: assert property (take |=> wb_ack_out || wb_err_out)
        else $error("bus request not answered in one cycle");
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out && !wb_err_out)
        else $error("ack held longer than one cycle");
    // Reset is the only other cause of a change, so it is excused here
    a_system_hold: assert property (
        !$stable(flags_out[5:4]) |-> ($past(|sys_evt_in) || $past(sys_rst_in)))
        else $error("watchdog or powerdown flag moved without an event");
    a_timeout_set: assert property (
        sys_evt_in.watchdog_timeout |=> flags_out[5])
        else $error("timeout did not set the watchdog flag");
    a_kick_clear: assert property (
        sys_evt_in.watchdog_kick_instruction && !sys_evt_in.watchdog_timeout
        && !sys_evt_in.sleep_entry_instruction |=> flags_out[5:4] == 2'h0)
        else $error("kick did not clear watchdog and powerdown flags");
    a_sleep_set: assert property (
        sys_evt_in.sleep_entry_instruction && !sys_evt_in.watchdog_timeout
        |=> flags_out[5:4] == 2'h1)
        else $error("sleep entry flags wrong");
    // Logic operations keep overflow, so the held value feeds sign xor
    a_sxor_value: assert property (
        sets_z |=> flags_out[7] == (flags_out[3] ^ $past(alu_req_in.result[7])))
        else $error("sign xor flag wrong");
    a_zero_value: assert property (
        sets_z |=> flags_out[2] == ($past(alu_req_in.result) == 8'h00))
        else $error("zero flag wrong");
    a_chain_load: assert property (is_sub |=> flags_out[6] == flags_out[2])
        else $error("subtract did not copy zero to chained flag");
    a_chain_and: assert property (
        is_sbc |=> flags_out[6] == ($past(flags_out[6]) && flags_out[2]))
        else $error("borrow subtract chained flag wrong");
    a_chain_keep: assert property (!is_sub && !is_sbc |=> $stable(flags_out[6]))
        else $error("chained flag changed outside subtracts");
endmodule // cfu_flag_unit_assertions

bind cfu_flag_unit cfu_flag_unit_assertions i_cfu_flag_unit_assertions (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .wb_err_out(wb_err_out),
    .alu_req_in(alu_req_in), .sys_evt_in(sys_evt_in), .flags_out(flags_out));
`default_nettype wire

// file: cfu_core_model.sv
// Purpose: ALU, decoder and watchdog as seen by the flag unit
// Assumes: Caller supplies carry_in as the core would
// Notes: Flags are never stacked here; software saves them itself
`timescale 1ns/1ps
`default_nettype none
module cfu_core_model (
    input  wire logic                 ref_clk_in,
    output var cfu_pkg::cfu_alu_req_t alu_req_out,
    output var cfu_pkg::cfu_sys_evt_t sys_evt_out
);
    function automatic logic [7:0] alu_res(input cfu_pkg::cfu_op_t op,
                                           input logic [7:0] a, b, input logic c);
        case (op)
            cfu_pkg::CFU_OP_ADD:             return a + b + {7'h00, c};
            cfu_pkg::CFU_OP_SUB,
            cfu_pkg::CFU_OP_SUB_BORROW:      return a + ~b + {7'h00, c};
            cfu_pkg::CFU_OP_LOGIC:           return a & b;
            cfu_pkg::CFU_OP_ROT_LEFT_CARRY:  return {a[6:0], c};
            cfu_pkg::CFU_OP_ROT_RIGHT_CARRY: return {c, a[7:1]};
            default:                         return a;
        endcase
    endfunction

    initial begin
        alu_req_out = '0;
        sys_evt_out = '0;
    end

    // One operation for exactly one edge; the stale result is inverted after
    task automatic issue(input cfu_pkg::cfu_op_t op, input logic [7:0] a, b, input logic c);
        @(posedge ref_clk_in);
        alu_req_out <= '{1'h1, op, a, b, c, alu_res(op, a, b, c)};
        @(posedge ref_clk_in);
        alu_req_out.valid  <= 1'h0;
        alu_req_out.result <= ~alu_req_out.result;
    endtask

    task automatic pulse(input logic [2:0] e);
        @(posedge ref_clk_in);
        sys_evt_out <= cfu_pkg::cfu_sys_evt_t'(e);
        @(posedge ref_clk_in);
        sys_evt_out <= '0;
    endtask
endmodule // cfu_core_model
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench of the condition flag unit
// Assumes: Ack or err comes one cycle after a request is taken
// Notes:   Expected flags are worked out by hand per operation
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                  ref_clk_in = 1'h0;
    logic                  sys_rst_in = 1'h1;
    logic                  wb_cyc_in  = 1'h0;
    logic                  wb_stb_in  = 1'h0;
    logic                  wb_we_in   = 1'h0;
    logic [7:0]            wb_adr_in  = 8'h00;
    logic [3:0]            wb_sel_in  = 4'h0;
    logic [31:0]           wb_dat_in  = 32'h0;
    logic [31:0]           wb_dat_out;
    logic [31:0]           rd;
    logic                  wb_ack_out;
    logic                  wb_err_out;
    logic                  rd_err;
    logic [7:0]            flags_out;
    cfu_pkg::cfu_alu_req_t alu_req;
    cfu_pkg::cfu_sys_evt_t sys_evt;
    int                    errors    = 0;
    int                    cmp_count = 0;
    int                    cycles    = 0;
    cfu_pkg::cfu_op_t      op_t [11] = '{cfu_pkg::CFU_OP_ADD, cfu_pkg::CFU_OP_SUB,
        cfu_pkg::CFU_OP_SUB_BORROW, cfu_pkg::CFU_OP_SUB_BORROW, cfu_pkg::CFU_OP_SUB_BORROW,
        cfu_pkg::CFU_OP_SUB, cfu_pkg::CFU_OP_LOGIC, cfu_pkg::CFU_OP_ROT_LEFT_CARRY,
        cfu_pkg::CFU_OP_ROT_RIGHT_CARRY, cfu_pkg::CFU_OP_ADD, cfu_pkg::CFU_OP_NONE};
    logic [7:0] a_t [11] = '{8'h7F, 8'h05, 8'h00, 8'h03, 8'h00, 8'h80, 8'hF0, 8'h01, 8'h01,
        8'hFF, 8'h55};
    logic [7:0] b_t [11] = '{8'h01, 8'h05, 8'h00, 8'h01, 8'h00, 8'h01, 8'h0F, 8'h00, 8'h00,
        8'h01, 8'h55};
    logic       c_t [11] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
    // Logic keeps overflow set, so sign xor follows it; rotates leave both overflow and sign xor unchanged
    logic [7:0] x_t [11] = '{8'h0A, 8'h47, 8'h47, 8'h03, 8'h07, 8'h89, 8'h8D, 8'h8C, 8'h8D,
        8'h07, 8'h07};

    cfu_flag_unit i_cfu_flag_unit (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .wb_err_out(wb_err_out),
        .alu_req_in(alu_req), .sys_evt_in(sys_evt), .flags_out(flags_out));
    cfu_core_model i_cfu_core_model (.ref_clk_in(ref_clk_in), .alu_req_out(alu_req),
        .sys_evt_out(sys_evt));

    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits for ack or err as long as it takes; only the bench timeout ends a hang
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                           input logic [31:0] dat);
        @(posedge ref_clk_in);
        wb_cyc_in <= 1'h1;
        wb_stb_in <= 1'h1;
        wb_we_in  <= we;
        wb_adr_in <= adr;
        wb_sel_in <= sel;
        wb_dat_in <= dat;
        do begin
            @(posedge ref_clk_in);
        end while (!(wb_ack_out === 1'h1 || wb_err_out === 1'h1));
        rd = wb_dat_out;
        rd_err = wb_err_out;
        wb_cyc_in <= 1'h0;
        wb_stb_in <= 1'h0;
    endtask

    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        repeat (20) @(posedge ref_clk_in);
        sys_rst_in <= 1'h0;
        wb_xfer(1'h0, 8'h00, 4'hF, 32'h0);
        check(rd, 32'h0);
        wb_xfer(1'h1, 8'h00, 4'hF, 32'hFFFF_FFFF);
        wb_xfer(1'h0, 8'h00, 4'hF, 32'h0);
        check(rd, 32'h0F);
        wb_xfer(1'h1, 8'h00, 4'hE, 32'h0);
        wb_xfer(1'h1, 8'h04, 4'hF, 32'h0);
        check({rd_err, flags_out}, 9'h00F);
        wb_xfer(1'h0, 8'h08, 4'hF, 32'h0);
        check(rd_err, 1'h1);
        wb_xfer(1'h0, 8'h04, 4'hF, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 11; i++) begin
            i_cfu_core_model.issue(op_t[i], a_t[i], b_t[i], c_t[i]);
            #1;
            check(flags_out, x_t[i]);
        end
        i_cfu_core_model.pulse(3'h1);
        wb_xfer(1'h1, 8'h00, 4'hF, 32'h0);
        wb_xfer(1'h0, 8'h00, 4'hF, 32'h0);
        check(rd, 32'h20);
        i_cfu_core_model.pulse(3'h2);
        #1;
        check(flags_out, 8'h10);
        i_cfu_core_model.pulse(3'h1);
        #1;
        check(flags_out, 8'h30);
        i_cfu_core_model.pulse(3'h4);
        #1;
        check(flags_out, 8'h00);
        i_cfu_core_model.pulse(3'h3);
        #1;
        check(flags_out, 8'h30);
        @(posedge ref_clk_in);
        sys_rst_in <= 1'h1;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'h0;
        #1;
        check(flags_out, 8'h00);
        final_report();
    end
endmodule // tb
`default_nettype wire
